// [design/csi_slot_if.v]
// stereo codec slot interface: two-slot network-mode serial port
// Notes on behaviour
// - the port runs in network mode with exactly two time slots per frame.
// - slot 0 of each 32-bit frame carries left, slot 1 carries right.
// - at each slot end the completed receive word is moved out and a receive event is raised.
// - at each slot end, in the same cycle as the receive event, a transmit event is raised so the next word can be supplied.
// - a transmit word is moved into the transmit shift register and shifted out serially.
// - each received 16-bit word sits in the top sixteen bits of a 24-bit word.
// - the low eight bits of that 24-bit word are zero.
// - samples received in one frame are processed in the following frame and sent out in the frame after that.
// - the left word must be supplied between frame sync rise and fall, within its budget.
// - the right word must be supplied within its budget from the end of slot 0.
`timescale 1ns/10ps
`include "csi_slot_regs.vh"
module csi_slot_if #(
   parameter [39:0] RIGHT_BUDGET_CYCLES = `CSI_RIGHT_CYC
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire bit_clk_i,
   input wire frame_sync_i,
   input wire serial_rx_i,
   output reg serial_tx_o,
   output reg rx_valid_o,
   output reg rx_slot_o,
   output reg [23:0] rx_word_o,
   output reg tx_req_o,
   output reg tx_req_slot_o,
   input wire tx_write_i,
   input wire tx_slot_i,
   input wire [23:0] tx_word_i,
   output reg left_miss_o,
   output reg right_miss_o,
   output wire link_active_o
);

   localparam [39:0] LEFT_BUDGET_CYCLES = `CSI_LEFT_CYC;
   localparam [1:0] ST_HUNT = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   // ----------------------------------------------------------------------
   // pin synchronisation and edge detection
   // ----------------------------------------------------------------------
   wire [2:0] pins_s;
   wire bclk_s;
   wire fs_s;
   wire rxd_s;

   csi_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i({bit_clk_i, frame_sync_i, serial_rx_i}),
      .sync_o(pins_s)
   );

   assign bclk_s = pins_s[2];
   assign fs_s = pins_s[1];
   assign rxd_s = pins_s[0];

   reg bclk_d_reg;
   reg fs_prev_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [4:0] bit_idx_reg;
   reg [15:0] rx_shift_reg;
   reg [15:0] tx_shift_reg;
   reg [15:0] left_buf_reg;
   reg [15:0] right_buf_reg;
   reg left_pend_reg;
   reg right_pend_reg;
   reg [15:0] left_cnt_reg;
   reg [15:0] right_cnt_reg;

   wire bclk_fall;
   wire bclk_rise;
   wire fs_start;
   wire fs_end;
   wire [4:0] cur_bit;
   wire running;
   wire slot_end;

   assign bclk_fall = bclk_d_reg & ~bclk_s;
   assign bclk_rise = ~bclk_d_reg & bclk_s;
   // frame sync is high for the whole of slot 0
   assign fs_start = bclk_fall & fs_s & ~fs_prev_reg;
   assign fs_end = bclk_fall & ~fs_s & fs_prev_reg;
   // bit position of the bit taken at this falling edge
   assign cur_bit = fs_start ? `CSI_BIT_FIRST : (bit_idx_reg + `CSI_BIT_STEP);
   assign running = (state_reg == ST_RUN) | fs_start;
   // only two slot boundaries per frame
   assign slot_end = bclk_fall & running &
                     ((cur_bit == `CSI_SLOT0_LAST) | (cur_bit == `CSI_SLOT1_LAST));
   assign link_active_o = (state_reg == ST_RUN);

   // ----------------------------------------------------------------------
   // link state
   // ----------------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_HUNT: begin
            if (fs_start) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_HUNT;
         end
      endcase
   end

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= ST_HUNT;
         bclk_d_reg <= 1'b0;
         fs_prev_reg <= 1'b0;
         bit_idx_reg <= `CSI_SLOT1_LAST;
      end else begin
         state_reg <= state_next;
         bclk_d_reg <= bclk_s;
         if (bclk_fall) begin
            fs_prev_reg <= fs_s;
            bit_idx_reg <= cur_bit;
         end
      end
   end

   // ----------------------------------------------------------------------
   // receive path
   // ----------------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_shift_reg <= `CSI_WORD_ZERO;
         rx_valid_o <= 1'b0;
         rx_slot_o <= `CSI_SLOT_LEFT;
         rx_word_o <= {`CSI_WORD_ZERO, `CSI_PAD_ZERO};
      end else begin
         rx_valid_o <= 1'b0;
         if (bclk_fall) begin
            rx_shift_reg <= {rx_shift_reg[14:0], rxd_s};
         end
         if (slot_end) begin
            // msb first, left justified with a zero low byte
            rx_word_o <= {rx_shift_reg[14:0], rxd_s, `CSI_PAD_ZERO};
            rx_slot_o <= cur_bit[4];
            rx_valid_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // transmit buffer and shifter
   // ----------------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         left_buf_reg <= `CSI_WORD_ZERO;
         right_buf_reg <= `CSI_WORD_ZERO;
      end else if (tx_write_i) begin
         // words land in the buffer and leave at the next matching slot
         if (tx_slot_i == `CSI_SLOT_LEFT) begin
            left_buf_reg <= tx_word_i[23:8];
         end else begin
            right_buf_reg <= tx_word_i[23:8];
         end
      end
   end

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_shift_reg <= `CSI_WORD_ZERO;
         serial_tx_o <= 1'b0;
         tx_req_o <= 1'b0;
         tx_req_slot_o <= `CSI_SLOT_LEFT;
      end else begin
         tx_req_o <= 1'b0;
         if (slot_end) begin
            // next slot is right after bit 15, left after bit 31
            if (cur_bit == `CSI_SLOT0_LAST) begin
               tx_shift_reg <= right_buf_reg;
               tx_req_slot_o <= `CSI_SLOT_RIGHT;
            end else begin
               tx_shift_reg <= left_buf_reg;
               tx_req_slot_o <= `CSI_SLOT_LEFT;
            end
            tx_req_o <= 1'b1;
         end else if (bclk_rise & link_active_o) begin
            // drive on rise so the codec samples a settled bit
            serial_tx_o <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------------
   // processing deadlines
   // ----------------------------------------------------------------------
   wire left_wr;
   wire right_wr;
   wire left_over;
   wire right_over;
   wire right_arm;

   assign left_wr = tx_write_i & (tx_slot_i == `CSI_SLOT_LEFT);
   assign right_wr = tx_write_i & (tx_slot_i == `CSI_SLOT_RIGHT);
   assign left_over = left_pend_reg & (({`CSI_CNT_PAD, left_cnt_reg} >= LEFT_BUDGET_CYCLES) | fs_end);
   assign right_over = right_pend_reg & ({`CSI_CNT_PAD, right_cnt_reg} >= RIGHT_BUDGET_CYCLES);
   assign right_arm = slot_end & (cur_bit == `CSI_SLOT0_LAST);

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         left_pend_reg <= 1'b0;
         left_cnt_reg <= `CSI_CNT_ZERO;
         left_miss_o <= 1'b0;
      end else begin
         left_miss_o <= 1'b0;
         if (fs_start) begin
            // a new frame arms the window; arming wins over a same-cycle write
            left_pend_reg <= 1'b1;
            left_cnt_reg <= `CSI_CNT_ZERO;
         end else if (left_over) begin
            left_pend_reg <= 1'b0;
            left_miss_o <= 1'b1;
         end else if (left_wr) begin
            left_pend_reg <= 1'b0;
         end else if (left_pend_reg) begin
            left_cnt_reg <= left_cnt_reg + `CSI_CNT_ONE;
         end
      end
   end

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         right_pend_reg <= 1'b0;
         right_cnt_reg <= `CSI_CNT_ZERO;
         right_miss_o <= 1'b0;
      end else begin
         right_miss_o <= 1'b0;
         if (right_arm) begin
            right_pend_reg <= 1'b1;
            right_cnt_reg <= `CSI_CNT_ZERO;
         end else if (right_over) begin
            right_pend_reg <= 1'b0;
            right_miss_o <= 1'b1;
         end else if (right_wr) begin
            right_pend_reg <= 1'b0;
         end else if (right_pend_reg) begin
            right_cnt_reg <= right_cnt_reg + `CSI_CNT_ONE;
         end
      end
   end

endmodule

// [design/csi_slot_regs.vh]
// constants for the stereo codec slot interface
`ifndef CSI_SLOT_REGS_VH
`define CSI_SLOT_REGS_VH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define CSI_BIT_FIRST 5'h00
`define CSI_BIT_STEP 5'h01
`define CSI_SLOT0_LAST 5'h0F
`define CSI_SLOT1_LAST 5'h1F
`define CSI_SLOT_LEFT 1'b0
`define CSI_SLOT_RIGHT 1'b1
`define CSI_PAD_ZERO 8'h00
`define CSI_WORD_ZERO 16'h0000
`define CSI_SAMPLE_RATE_HZ 32'h0000BB80

// ----------------------------------------------------------------------
// processing budgets, in core clocks of the reference processor
// ----------------------------------------------------------------------
`define CSI_LEFT_BUDGET_CORE 40'h0000000702
`define CSI_RIGHT_BUDGET_CORE 40'h000000E73E
`define CSI_CORE_FREQ_KHZ 40'h0000015000
`define CSI_REF_FREQ_KHZ 40'h0000009C40
`define CSI_LEFT_CYC ((`CSI_LEFT_BUDGET_CORE * `CSI_REF_FREQ_KHZ) / `CSI_CORE_FREQ_KHZ)
`define CSI_RIGHT_CYC ((`CSI_RIGHT_BUDGET_CORE * `CSI_REF_FREQ_KHZ) / `CSI_CORE_FREQ_KHZ)
`define CSI_CNT_ZERO 16'h0000
`define CSI_CNT_ONE 16'h0001
`define CSI_CNT_PAD 24'h000000

`endif

// [design/csi_sync.v]
// two-stage synchroniser for the codec link pins
`timescale 1ns/10ps
module csi_sync (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire [2:0] async_i,
   output wire [2:0] sync_o
);

   reg [2:0] meta_reg;
   reg [2:0] sync_reg;

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule

// [verif/csi_slot_if_sva.sv]
// assertion checker for the codec slot interface
`timescale 1ns/10ps
module csi_slot_if_sva #(
   parameter [39:0] RIGHT_BUDGET_CYCLES = 40'h6B88
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire serial_tx_o,
   input wire rx_valid_o,
   input wire rx_slot_o,
   input wire [23:0] rx_word_o,
   input wire tx_req_o,
   input wire tx_req_slot_o,
   input wire left_miss_o,
   input wire right_miss_o,
   input wire link_active_o
);
   reg [39:0] cnt_reg;
   reg [15:0] gap_reg;
   reg seen_reg;
   reg last_reg;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // cycles since the left slot ended, and since any slot ended
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= 40'h0;
         gap_reg <= 16'h0;
         seen_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         cnt_reg <= (rx_valid_o && !rx_slot_o) ? 40'h1 : cnt_reg + 40'h1;
         gap_reg <= rx_valid_o ? 16'h1 : gap_reg + 16'h1;
         seen_reg <= seen_reg | rx_valid_o;
         last_reg <= rx_valid_o ? rx_slot_o : last_reg;
      end
   end
   a_pad_zero: assert property (rx_valid_o |-> rx_word_o[7:0] == 8'h00)
      else $error("low byte of received word not zero");
   a_tx_with_rx: assert property (rx_valid_o |-> tx_req_o && tx_req_slot_o != rx_slot_o)
      else $error("transmit event missing at slot change");
   a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("receive event longer than one cycle");
   a_word_hold: assert property (!rx_valid_o |-> $stable(rx_word_o) && $stable(rx_slot_o))
      else $error("received word changed without event");
   a_idle_quiet: assert property (!link_active_o |-> !rx_valid_o && !tx_req_o && !serial_tx_o)
      else $error("activity before first frame");
   a_slot_order: assert property (rx_valid_o && seen_reg |->
      rx_slot_o != last_reg && gap_reg >= 16'h7E && gap_reg <= 16'h82)
      else $error("slot order or slot length wrong");
   a_left_late: assert property (left_miss_o |-> cnt_reg >= 40'h1 && cnt_reg <= 40'h10)
      else $error("left miss at wrong time");
   a_right_late: assert property (right_miss_o |->
      cnt_reg + 40'h2 >= RIGHT_BUDGET_CYCLES && cnt_reg <= RIGHT_BUDGET_CYCLES + 40'h2)
      else $error("right miss at wrong time");
   a_miss_pulse: assert property ((left_miss_o || right_miss_o) |=> !left_miss_o && !right_miss_o)
      else $error("miss flag longer than one cycle");
   a_link_holds: assert property (link_active_o |=> link_active_o)
      else $error("link activity dropped");
endmodule

bind csi_slot_if csi_slot_if_sva #(.RIGHT_BUDGET_CYCLES(RIGHT_BUDGET_CYCLES)) u_csi_slot_if_sva (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .serial_tx_o(serial_tx_o), .rx_valid_o(rx_valid_o),
   .rx_slot_o(rx_slot_o), .rx_word_o(rx_word_o), .tx_req_o(tx_req_o), .tx_req_slot_o(tx_req_slot_o),
   .left_miss_o(left_miss_o), .right_miss_o(right_miss_o), .link_active_o(link_active_o));

// [verif/csi_codec_model.sv]
// behavioural codec: frame timing, serial data out, capture of returned words
`timescale 1ns/10ps
module csi_codec_model (
   input wire run_i,
   input wire [15:0] left_i,
   input wire [15:0] right_i,
   input wire tx_i,
   output logic bclk_o,
   output logic fs_o,
   output logic rx_o,
   output logic [15:0] left_o,
   output logic [15:0] right_o
);
   logic [31:0] cap;
   initial begin
      bclk_o = 1'b0;
      fs_o = 1'b0;
      rx_o = 1'b0;
      left_o = 16'h0;
      right_o = 16'h0;
      wait (run_i === 1'b1);
      #7;
      forever begin
         for (int n = 0; n < 32; n++) begin
            bclk_o = 1'b1;
            fs_o = (n < 16);
            rx_o = (n < 16) ? left_i[15 - n] : right_i[31 - n];
            #100;
            bclk_o = 1'b0;
            cap[31 - n] = tx_i;
            #100;
         end
         left_o = cap[31:16];
         right_o = cap[15:0];
      end
   end
endmodule

// [verif/tb_csi_slot_if.sv]
// testbench for the codec slot interface
`timescale 1ns/10ps
module tb_csi_slot_if;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic run = 1'b0;
   logic tx_write_i = 1'b0;
   logic tx_slot_i = 1'b0;
   logic [23:0] tx_word_i = 24'h0;
   wire bclk, fs, srx, serial_tx_o, rx_valid_o, rx_slot_o, tx_req_o, tx_req_slot_o;
   wire left_miss_o, right_miss_o, link_active_o;
   wire [23:0] rx_word_o;
   wire [15:0] cap_l, cap_r;
   int bad_count = 0;
   int checks = 0;
   int lm = 0;
   int rm = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      lm <= lm + int'(left_miss_o);
      rm <= rm + int'(right_miss_o);
   end
   csi_slot_if #(.RIGHT_BUDGET_CYCLES(40'hC8)) u_csi_slot_if (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .bit_clk_i(bclk), .frame_sync_i(fs), .serial_rx_i(srx), .serial_tx_o(serial_tx_o),
      .rx_valid_o(rx_valid_o), .rx_slot_o(rx_slot_o), .rx_word_o(rx_word_o), .tx_req_o(tx_req_o),
      .tx_req_slot_o(tx_req_slot_o), .tx_write_i(tx_write_i), .tx_slot_i(tx_slot_i), .tx_word_i(tx_word_i),
      .left_miss_o(left_miss_o), .right_miss_o(right_miss_o), .link_active_o(link_active_o));
   csi_codec_model u_csi_codec_model (.run_i(run), .left_i(16'hA5C3), .right_i(16'h3C5A), .tx_i(serial_tx_o),
      .bclk_o(bclk), .fs_o(fs), .rx_o(srx), .left_o(cap_l), .right_o(cap_r));
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ev(input logic slot);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      #1;
      while (!(rx_valid_o === 1'b1 && rx_slot_o === slot) && n < 400) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      cmp({23'h0, n < 400}, 24'h1);
   endtask
   task automatic put(input logic slot, input logic [23:0] w);
      @(posedge ref_clk_i);
      tx_write_i <= 1'b1;
      tx_slot_i <= slot;
      tx_word_i <= w;
      @(posedge ref_clk_i);
      tx_write_i <= 1'b0;
   endtask
   task automatic t_idle;
      repeat (20) @(posedge ref_clk_i);
      #1;
      cmp({22'h0, link_active_o, serial_tx_o}, 24'h0);
      run <= 1'b1;
   endtask
   task automatic t_miss;
      int l0, r0;
      wait_ev(1'b0);
      l0 = lm;
      r0 = rm;
      repeat (250) @(posedge ref_clk_i);
      cmp(24'(lm - l0), 24'h1);
      cmp(24'(rm - r0), 24'h1);
   endtask
   task automatic t_loop;
      int l0, r0;
      wait_ev(1'b1);
      l0 = lm;
      r0 = rm;
      // right window armed at the last slot 0 end is still open
      put(1'b1, 24'h5AF0FF);
      repeat (20) @(posedge ref_clk_i);
      put(1'b0, 24'hC3817E);
      wait_ev(1'b0);
      cmp(rx_word_o, 24'hA5C300);
      put(1'b1, 24'h5AF0FF);
      wait_ev(1'b1);
      cmp(rx_word_o, 24'h3C5A00);
      cmp(24'(lm - l0 + rm - r0), 24'h0);
      wait_ev(1'b1);
      repeat (8) @(posedge ref_clk_i);
      cmp({8'h0, cap_l}, 24'h00C381);
      cmp({8'h0, cap_r}, 24'h005AF0);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #100us;
      bad_count++;
      results;
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      t_idle;
      t_miss;
      t_loop;
      results;
   end
endmodule
